// [rtl/wdt_defs.vh]
// Constants of the watchdog timer: register indices, field positions, reset values and command codes.
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define WDT_IDX_CTRL 8'h34
`define WDT_IDX_CODE 8'h35
`define WDT_IDX_STATUS 8'h36
`define WDT_IDX_CLEAR 8'h37
`define WDT_IDX_ENABLE 8'h38
`define WDT_IDX_STATE 8'h39

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define WDT_CTRL_ACTION_BIT 0
`define WDT_CTRL_PERIOD_LSB 1
`define WDT_CTRL_PERIOD_MSB 2
`define WDT_CTRL_RUN_BIT 3
`define WDT_CTRL_TRAP_ACT_BIT 4
`define WDT_CTRL_TRAP_AREA_BIT 5

// ----------------------------------------------------------------------------
// Reset values of the control fields
// ----------------------------------------------------------------------------
`define WDT_RST_ACTION 1'b1
`define WDT_RST_PERIOD 2'b00
`define WDT_RST_RUN 1'b1
`define WDT_RST_TRAP_ACT 1'b1
`define WDT_RST_TRAP_AREA 1'b1
`define WDT_RST_ACTIVE 1'b1

// ----------------------------------------------------------------------------
// Command codes of the code register
// ----------------------------------------------------------------------------
`define WDT_CODE_CLEAR 8'h4E
`define WDT_CODE_DISABLE 8'hB1
`define WDT_CODE_TRAP 8'hD2

// ----------------------------------------------------------------------------
// Event status bits (status, clear and enable share this layout)
// ----------------------------------------------------------------------------
`define WDT_EVT_WIDTH 3
`define WDT_EVT_IRQ_BIT 0
`define WDT_EVT_RESET_BIT 1
`define WDT_EVT_BADCODE_BIT 2
`define WDT_RST_EVT_ENABLE 3'h0

// ----------------------------------------------------------------------------
// State register fields
// ----------------------------------------------------------------------------
`define WDT_ST_ACTIVE_BIT 0
`define WDT_ST_ACTION_BIT 1
`define WDT_ST_PERIOD_LSB 2
`define WDT_ST_PERIOD_MSB 3
`define WDT_ST_RUN_BIT 4
`define WDT_ST_BIN_LSB 5
`define WDT_ST_BIN_MSB 6
`define WDT_ST_SLOWSRC_BIT 7

// ----------------------------------------------------------------------------
// Counter geometry
// ----------------------------------------------------------------------------
`define WDT_BIN_LAST 2'b11
`define WDT_FC_TAP_BASE 23
`define WDT_FS_TAP_BASE 15
`define WDT_DIV_WIDTH 23

`endif

// [rtl/wdt_sync.v]
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none

module wdt_sync (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire async_in,
  output reg sync_out
);

  reg meta;

  // ----------------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------------
  // The first stage feeds only the second, so no logic sees a metastable value.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce)
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// [rtl/wdt_timer.v]
// Watchdog timer with divider, two-stage binary counter and AHB-Lite register slave.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.vh"

module wdt_timer #(
  parameter FC_TAP_BASE = `WDT_FC_TAP_BASE,
  parameter FS_TAP_BASE = `WDT_FS_TAP_BASE,
  parameter DIV_WIDTH = `WDT_DIV_WIDTH
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire fs_clk_in,
  input wire low_speed_run_mode,
  input wire low_freq_prescale_select,
  input wire stop_mode,
  input wire stop_warmup,
  input wire idle_mode,
  input wire sleep_mode,
  output reg watchdog_overflow_irq,
  output reg wdt_reset_request,
  output reg irq,
  output reg trap_area_commit,
  output reg ram_trap_area_select,
  output reg trap_action_select
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  localparam [4:0] FC_BASE = FC_TAP_BASE[4:0];
  localparam [4:0] FS_BASE = FS_TAP_BASE[4:0];

  reg dp_write;
  reg dp_hit;
  reg [7:0] dp_index;
  reg overflow_action_select;
  reg [1:0] detection_period_select;
  reg watchdog_run_bit;
  reg trap_area_pending;
  reg wdt_active;
  reg [DIV_WIDTH-1:0] divider;
  reg [1:0] bin_count;
  reg [`WDT_EVT_WIDTH-1:0] evt_status;
  reg [`WDT_EVT_WIDTH-1:0] evt_enable;
  reg fs_prev;
  reg [31:0] next_rdata;
  reg [4:0] tap;
  reg [`WDT_EVT_WIDTH-1:0] next_status;
  reg [`WDT_EVT_WIDTH-1:0] evt_set;
  reg [`WDT_EVT_WIDTH-1:0] evt_clr;
  wire fs_sync;
  wire addr_accept;
  wire [7:0] wdata;
  wire wr_ctrl;
  wire wr_code;
  wire wr_clear;
  wire wr_enable;
  wire code_clear;
  wire code_disable;
  wire code_trap;
  wire code_bad;
  wire paused;
  wire use_slow_src;
  wire fs_rise;
  wire step;
  wire [DIV_WIDTH-1:0] tap_mask;
  wire div_tick;
  wire overflow;

  // ----------------------------------------------------------------------------
  // Low-frequency clock input
  // ----------------------------------------------------------------------------
  // The slow clock arrives from a pin, so it is synchronised before its edge is found.
  wdt_sync u_fs_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in(fs_clk_in),
    .sync_out(fs_sync)
  );

  // Edge detector on the synchronised slow clock.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fs_prev <= 1'b0;
    end
    else if (ce)
    begin
      fs_prev <= fs_sync;
    end
  end

  assign fs_rise = fs_sync & ~fs_prev;

  // ----------------------------------------------------------------------------
  // AHB-Lite address phase and data phase capture
  // ----------------------------------------------------------------------------
  // Only the index bits decode; everything above the 1 KiB window must be zero.
  assign addr_accept = hsel & hready & htrans[1];

  // The slave never inserts wait states and always answers OKAY.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dp_write <= 1'b0;
      dp_hit <= 1'b0;
      dp_index <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        dp_write <= addr_accept & hwrite;
        dp_hit <= addr_accept & (haddr[31:10] == 22'h000000);
        dp_index <= haddr[9:2];
      end
    end
  end

  // Write strobes of the data phase; only the low byte lane carries data.
  assign wdata = hwdata[7:0];
  assign wr_ctrl = dp_write & dp_hit & (dp_index == `WDT_IDX_CTRL);
  assign wr_code = dp_write & dp_hit & (dp_index == `WDT_IDX_CODE);
  assign wr_clear = dp_write & dp_hit & (dp_index == `WDT_IDX_CLEAR);
  assign wr_enable = dp_write & dp_hit & (dp_index == `WDT_IDX_ENABLE);

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  // Read data is formed in the address phase and registered, so hrdata comes from a flop.
  // The write-only control and code registers read as zero.
  always @*
  begin
    next_rdata = 32'h00000000;
    if (haddr[31:10] == 22'h000000)
    begin
      case (haddr[9:2])
        `WDT_IDX_STATUS:
        begin
          next_rdata[`WDT_EVT_WIDTH-1:0] = evt_status;
        end
        `WDT_IDX_ENABLE:
        begin
          next_rdata[`WDT_EVT_WIDTH-1:0] = evt_enable;
        end
        `WDT_IDX_STATE:
        begin
          next_rdata[`WDT_ST_ACTIVE_BIT] = wdt_active;
          next_rdata[`WDT_ST_ACTION_BIT] = overflow_action_select;
          next_rdata[`WDT_ST_PERIOD_MSB:`WDT_ST_PERIOD_LSB] = detection_period_select;
          next_rdata[`WDT_ST_RUN_BIT] = watchdog_run_bit;
          next_rdata[`WDT_ST_BIN_MSB:`WDT_ST_BIN_LSB] = bin_count;
          next_rdata[`WDT_ST_SLOWSRC_BIT] = use_slow_src;
        end
        default:
        begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // Hold the last read word so the data phase sees a stable value.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
      if (addr_accept & ~hwrite)
      begin
        hrdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Command code decode
  // ----------------------------------------------------------------------------
  assign code_clear = wr_code & (wdata == `WDT_CODE_CLEAR);
  assign code_disable = wr_code & (wdata == `WDT_CODE_DISABLE);
  assign code_trap = wr_code & (wdata == `WDT_CODE_TRAP);
  // Any other value is ignored apart from being logged as a bad code.
  assign code_bad = wr_code & ~code_clear & ~code_disable & ~code_trap;

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  // Reset values put the watchdog in reset-request mode with the longest period.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      overflow_action_select <= `WDT_RST_ACTION;
      detection_period_select <= `WDT_RST_PERIOD;
      watchdog_run_bit <= `WDT_RST_RUN;
      trap_action_select <= `WDT_RST_TRAP_ACT;
      trap_area_pending <= `WDT_RST_TRAP_AREA;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        // The action bit can only fall; a later one is ANDed away until reset.
        overflow_action_select <= overflow_action_select & wdata[`WDT_CTRL_ACTION_BIT];
        detection_period_select <= wdata[`WDT_CTRL_PERIOD_MSB:`WDT_CTRL_PERIOD_LSB];
        watchdog_run_bit <= wdata[`WDT_CTRL_RUN_BIT];
        trap_action_select <= wdata[`WDT_CTRL_TRAP_ACT_BIT];
        trap_area_pending <= wdata[`WDT_CTRL_TRAP_AREA_BIT];
      end
    end
  end

  // The trap area selection only takes effect when the trap code is written.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ram_trap_area_select <= `WDT_RST_TRAP_AREA;
      trap_area_commit <= 1'b0;
    end
    else if (ce)
    begin
      trap_area_commit <= code_trap;
      if (code_trap)
      begin
        ram_trap_area_select <= trap_area_pending;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------------------
  // Clearing the run bit alone never stops the timer; the disable code must follow,
  // and it is honoured only while the run bit already reads zero.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdt_active <= `WDT_RST_ACTIVE;
    end
    else if (ce)
    begin
      if (wr_ctrl & wdata[`WDT_CTRL_RUN_BIT])
      begin
        wdt_active <= 1'b1;
      end
      else if (code_disable & ~watchdog_run_bit)
      begin
        wdt_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Clock source, pause and divider tap
  // ----------------------------------------------------------------------------
  // Low-power modes freeze the counters, which keep their value for resumption.
  assign paused = stop_mode | stop_warmup | idle_mode | sleep_mode;
  assign use_slow_src = low_speed_run_mode | low_freq_prescale_select;
  assign step = wdt_active & ~paused & (use_slow_src ? fs_rise : 1'b1);

  // The binary counter adds two bits, so the divider tap is the period exponent minus two.
  always @*
  begin
    tap = (use_slow_src ? FS_BASE : FC_BASE) - {2'b00, detection_period_select, 1'b0};
  end

  assign tap_mask = ~({DIV_WIDTH{1'b1}} << tap);
  assign div_tick = step & (&(divider | ~tap_mask));

  // ----------------------------------------------------------------------------
  // Divider and binary counter
  // ----------------------------------------------------------------------------
  // A kick leaves the divider alone, so the next overflow may come after only
  // three quarters of the period; that is why software kicks more often.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      divider <= {DIV_WIDTH{1'b0}};
    end
    else if (ce)
    begin
      if (~wdt_active)
      begin
        divider <= {DIV_WIDTH{1'b0}};
      end
      else if (step)
      begin
        divider <= divider + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // A kick in the same cycle as a tick wins, so a timely kick never overflows.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bin_count <= 2'b00;
    end
    else if (ce)
    begin
      if (~wdt_active)
      begin
        bin_count <= 2'b00;
      end
      else if (code_clear)
      begin
        bin_count <= 2'b00;
      end
      else if (div_tick)
      begin
        bin_count <= bin_count + 2'b01;
      end
    end
  end

  assign overflow = div_tick & (bin_count == `WDT_BIN_LAST) & ~code_clear;

  // ----------------------------------------------------------------------------
  // Overflow actions
  // ----------------------------------------------------------------------------
  // Both requests are one-cycle pulses. The interrupt request is not gated by the
  // event enable mask, because the processor treats it as non-maskable.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdt_reset_request <= 1'b0;
      watchdog_overflow_irq <= 1'b0;
    end
    else if (ce)
    begin
      wdt_reset_request <= overflow & overflow_action_select;
      watchdog_overflow_irq <= overflow & ~overflow_action_select;
    end
  end

  // ----------------------------------------------------------------------------
  // Event status, clear and enable
  // ----------------------------------------------------------------------------
  // A new event in the cycle of its clear survives, since the set term is ORed last.
  always @*
  begin
    evt_set = {`WDT_EVT_WIDTH{1'b0}};
    evt_set[`WDT_EVT_IRQ_BIT] = overflow & ~overflow_action_select;
    evt_set[`WDT_EVT_RESET_BIT] = overflow & overflow_action_select;
    evt_set[`WDT_EVT_BADCODE_BIT] = code_bad;
    evt_clr = wr_clear ? wdata[`WDT_EVT_WIDTH-1:0] : {`WDT_EVT_WIDTH{1'b0}};
    next_status = (evt_status & ~evt_clr) | evt_set;
  end

  // The interrupt line follows the next status so it rises with the sticky bit.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      evt_status <= {`WDT_EVT_WIDTH{1'b0}};
      evt_enable <= `WDT_RST_EVT_ENABLE;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      evt_status <= next_status;
      if (wr_enable)
      begin
        evt_enable <= wdata[`WDT_EVT_WIDTH-1:0];
      end
      irq <= |(next_status & (wr_enable ? wdata[`WDT_EVT_WIDTH-1:0] : evt_enable));
    end
  end

endmodule

`default_nettype wire

// [testbench/wdt_timer_chk.sv]
// Concurrent checks on the watchdog timer ports.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.vh"

module wdt_timer_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_mode,
  input wire logic stop_warmup,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic watchdog_overflow_irq,
  input wire logic wdt_reset_request,
  input wire logic irq,
  input wire logic trap_area_commit,
  input wire logic ram_trap_area_select,
  input wire logic trap_action_select
);
  // ----------------------------------------------------------------
  // Data phase tracking
  // ----------------------------------------------------------------
  logic wr_ctl, wr_code, rd_ctl, area_q;
  wire logic take = hsel && hready && htrans[1];
  wire logic pause = stop_mode || stop_warmup || idle_mode || sleep_mode;

  // Flags mark the data phase of a taken transfer; area_q keeps the last written area bit.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {wr_ctl, wr_code, rd_ctl} <= 3'h0;
      area_q <= 1'b1;
    end
    else
    begin
      wr_ctl <= take && hwrite && haddr == {22'h0, `WDT_IDX_CTRL, 2'b00};
      wr_code <= take && hwrite && haddr == {22'h0, `WDT_IDX_CODE, 2'b00};
      rd_ctl <= take && !hwrite && haddr == {22'h0, `WDT_IDX_CTRL, 2'b00};
      if (wr_ctl)
        area_q <= hwdata[5];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_pulse_one: assert property (wdt_reset_request |=> !wdt_reset_request)
    else $error("reset request wider than one cycle");
  a_irq_pulse_one: assert property (watchdog_overflow_irq |=> !watchdog_overflow_irq)
    else $error("overflow interrupt wider than one cycle");
  a_action_exclusive: assert property (!(watchdog_overflow_irq && wdt_reset_request))
    else $error("both overflow actions at once");
  a_pause_silent: assert property (pause && $past(pause) |-> !wdt_reset_request && !watchdog_overflow_irq)
    else $error("overflow while paused");
  a_commit_on_code: assert property (wr_code && hwdata[7:0] == `WDT_CODE_TRAP |-> ##[1:2] trap_area_commit)
    else $error("trap code without commit");
  a_area_on_commit: assert property ($changed(ram_trap_area_select) |-> trap_area_commit || $past(trap_area_commit))
    else $error("trap area changed without commit");
  a_area_value: assert property (trap_area_commit |-> ##[0:1] ram_trap_area_select == area_q)
    else $error("committed trap area wrong");
  a_action_direct: assert property (wr_ctl |=> trap_action_select == $past(hwdata[4]))
    else $error("trap action bit not taken");
  a_ctl_reads_zero: assert property (rd_ctl |-> hrdata == 32'h0)
    else $error("control register read not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");

  c_reset: cover property (wdt_reset_request);
  c_irq_pulse: cover property (watchdog_overflow_irq);
  c_commit: cover property (trap_area_commit);
  c_irq_level: cover property (irq);
endmodule

bind wdt_timer wdt_timer_chk chk_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .stop_mode(stop_mode), .stop_warmup(stop_warmup), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
  .watchdog_overflow_irq(watchdog_overflow_irq), .wdt_reset_request(wdt_reset_request), .irq(irq),
  .trap_area_commit(trap_area_commit), .ram_trap_area_select(ram_trap_area_select),
  .trap_action_select(trap_action_select));
`default_nettype wire

// [testbench/test_watchdog_timer.sv]
// Self-checking testbench of the watchdog timer.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defs.vh"

module test_watchdog_timer;
  // ----------------------------------------------------------------
  // Stimulus, clocks and design
  // ----------------------------------------------------------------
  localparam int TB = 6;
  localparam logic [31:0] A_CTL = {22'h0, `WDT_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_CODE = {22'h0, `WDT_IDX_CODE, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, `WDT_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_CLR = {22'h0, `WDT_IDX_CLEAR, 2'b00};
  localparam logic [31:0] A_EN = {22'h0, `WDT_IDX_ENABLE, 2'b00};
  localparam logic [31:0] A_ST = {22'h0, `WDT_IDX_STATE, 2'b00};
  logic clk_sys = 1'b0;
  logic fs_clk_in = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic presc = 1'b0;
  logic [3:0] pause = 4'h0;
  wire logic hready, hresp, wirq, wrst, irq, tcommit, tarea, tact;
  wire logic [31:0] hrdata;
  int num_errors = 0;
  int check_count = 0;
  int cyc;
  logic [31:0] rd;

  // The slow clock runs at a tenth of the system rate, well under the synchroniser limit.
  always #2 clk_sys = ~clk_sys;
  always #20 fs_clk_in = ~fs_clk_in;

  wdt_timer #(.FC_TAP_BASE(TB), .FS_TAP_BASE(TB)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .fs_clk_in(fs_clk_in), .low_speed_run_mode(slow), .low_freq_prescale_select(presc),
    .stop_mode(pause[0]), .stop_warmup(pause[1]), .idle_mode(pause[2]), .sleep_mode(pause[3]),
    .watchdog_overflow_irq(wirq), .wdt_reset_request(wrst), .irq(irq), .trap_area_commit(tcommit),
    .ram_trap_area_select(tarea), .trap_action_select(tact));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("BAD t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
    end
  endtask

  // A bus wait that never ends is a fault, so the run is closed there.
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50)
    begin
      num_errors++;
      test_done;
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready;
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check_val(rd & m, e);
  endtask

  // Counts cycles until the chosen overflow pulse, giving up at the limit.
  task automatic wait_evt(input logic s, input int lim);
    cyc = 0;
    @(posedge clk_sys);
    while ((s ? wrst : wirq) !== 1'b1 && cyc < lim)
    begin
      @(posedge clk_sys);
      cyc++;
    end
  endtask

  // The divider is not cleared by a kick, so anything from three quarters of a period is legal.
  task automatic ovf_chk(input logic s, input int per, input int sl);
    wait_evt(s, 2 * per + 20);
    check_rng(cyc, 3 * per / 4 - sl, per + sl);
  endtask

  function automatic logic [7:0] ctl(input logic a, input logic [1:0] p, input logic r);
    return {4'b0011, r, p, a};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    check_val(32'({tact, tarea, irq}), 32'h6);
    rd_chk(A_ST, 32'h9F, 32'h13);
    rd_chk(A_CTL, 32'hFF, 32'h00);
    rd_chk(32'h4E4, 32'hFF, 32'h00);
    wait_evt(1'b1, 300);
    check_rng(cyc, 200, 256);
    $display("reset test done");
    for (int p = 0; p < 4; p++)
    begin
      bus(1'b1, A_CTL, ctl(1'b1, p[1:0], 1'b1));
      bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
      ovf_chk(1'b1, 1 << (TB + 2 - 2 * p), 3);
    end
    bus(1'b1, A_CTL, ctl(1'b1, 2'd1, 1'b1));
    repeat (4)
    begin
      bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
      wait_evt(1'b1, 40);
      check_rng(cyc, 40, 40);
    end
    $display("period test done");
    bus(1'b1, A_CTL, ctl(1'b1, 2'd2, 1'b1));
    // The fifth pass freezes the whole block through its clock enable instead of a mode.
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
      pause <= 4'h1 << i;
      ce <= (i != 4);
      wait_evt(1'b1, 64);
      check_rng(cyc, 64, 64);
      pause <= 4'h0;
      ce <= 1'b1;
      ovf_chk(1'b1, 16, 3);
    end
    $display("pause test done");
    for (int i = 0; i < 2; i++)
    begin
      {slow, presc} <= 2'b10 >> i;
      bus(1'b1, A_CTL, ctl(1'b1, 2'd2, 1'b1));
      rd_chk(A_ST, 32'h80, 32'h80);
      bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
      ovf_chk(1'b1, 160, 15);
    end
    {slow, presc} <= 2'b00;
    $display("slow clock test done");
    bus(1'b1, A_CTL, ctl(1'b1, 2'd3, 1'b0));
    rd_chk(A_ST, 32'h01, 32'h01);
    bus(1'b1, A_CTL, ctl(1'b1, 2'd3, 1'b1));
    bus(1'b1, A_CODE, `WDT_CODE_DISABLE);
    rd_chk(A_ST, 32'h01, 32'h01);
    bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
    bus(1'b1, A_CTL, ctl(1'b1, 2'd3, 1'b0));
    bus(1'b1, A_CODE, `WDT_CODE_DISABLE);
    rd_chk(A_ST, 32'h61, 32'h00);
    wait_evt(1'b1, 100);
    check_rng(cyc, 100, 100);
    bus(1'b1, A_CTL, ctl(1'b1, 2'd3, 1'b1));
    ovf_chk(1'b1, 4, 3);
    $display("disable test done");
    bus(1'b1, A_CTL, 8'h09);
    repeat (2) @(posedge clk_sys);
    check_val(32'({tact, tarea}), 32'h1);
    bus(1'b1, A_CODE, `WDT_CODE_TRAP);
    repeat (2) @(posedge clk_sys);
    check_val(32'({tact, tarea}), 32'h0);
    bus(1'b1, A_EN, 8'h04);
    bus(1'b1, A_CODE, 8'h55);
    rd_chk(A_STAT, 32'h4, 32'h4);
    check_val(32'(irq), 32'h1);
    bus(1'b1, A_EN, 8'h00);
    @(posedge clk_sys);
    check_val(32'(irq), 32'h0);
    bus(1'b1, A_EN, 8'h04);
    bus(1'b1, A_CLR, 8'h04);
    rd_chk(A_STAT, 32'h4, 32'h0);
    check_val(32'(irq), 32'h0);
    $display("code test done");
    bus(1'b1, A_CTL, ctl(1'b0, 2'd3, 1'b1));
    bus(1'b1, A_CTL, ctl(1'b1, 2'd3, 1'b1));
    rd_chk(A_ST, 32'h02, 32'h00);
    bus(1'b1, A_CODE, `WDT_CODE_CLEAR);
    ovf_chk(1'b0, 4, 3);
    wait_evt(1'b1, 40);
    check_rng(cyc, 40, 40);
    rd_chk(A_STAT, 32'h1, 32'h1);
    $display("interrupt action test done");
    // A reset in mid-run must bring back the running state and the reset action.
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(A_ST, 32'h13, 32'h13);
    $display("second reset test done");
    test_done;
  end
endmodule
`default_nettype wire
